// ### include/ep_pkg.sv
/*
 Shared constants for the serial-bus memory slave and its bus controller.
 Assumes a 100 MHz system clock feeding both ends.
*/
package ep_pkg;
	localparam int CLK_PERIOD_NS = 10;
	// shortest bus clock period at the fast bus rate
	localparam int SCL_PERIOD_NS = 2500;
	// a quarter period, rounded up so the bus never runs too fast
	localparam int QTR_CYC = (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
	// internal programming time
	localparam int PROG_TIME_US = 5000;
	localparam int PROG_CYC = PROG_TIME_US * 1000 / CLK_PERIOD_NS;
	localparam int BYTE_W = 8;
	localparam int ADDR_W = 8;
	localparam int OFF_W = 4;
	localparam int PAGE_N = 16;
	localparam int MEM_N = 256;
	// slave address: high nibble 1010, low bits 000
	localparam logic [6:0] DEV_ADDR = 7'h50;
	localparam logic [3:0] BIT_ACK = 4'h8;
	localparam logic [3:0] BIT_END = 4'h9;
	localparam logic [3:0] BIT_STEP = 4'h1;
	localparam logic [ADDR_W-1:0] ADDR_STEP = 8'h01;
	localparam logic [OFF_W-1:0] OFF_STEP = 4'h1;
	localparam logic [PAGE_N-1:0] MASK_NONE = 16'h0000;
	localparam logic [1:0] PH_LAST = 2'h3;

	typedef enum logic [1:0]
	{
		OP_START = 2'b00,
		OP_WRITE = 2'b01,
		OP_READ = 2'b10,
		OP_STOP = 2'b11
	} ep_op_e;

	// address step that stays inside the current page
	function automatic logic [ADDR_W-1:0] ep_page_inc(input logic [ADDR_W-1:0] a);
		ep_page_inc = {a[ADDR_W-1:OFF_W], a[OFF_W-1:0] + OFF_STEP};
	endfunction
endpackage

// ### include/ep_bus_if.sv
/*
 Two-wire bus between the controller and the memory slave.
 Assumes open-drain data: a party only ever pulls low, the wire resolves here.
*/
`timescale 1ns/10ps
`default_nettype none
interface ep_bus_if;
	logic scl;
	logic sda_m_oe;
	logic sda_s_oe;
	wire sda;

	// pulled up unless someone drives it low
	assign sda = ~(sda_m_oe | sda_s_oe);

	modport master
	(
		output scl,
		output sda_m_oe,
		input sda
	);
	modport slave
	(
		input scl,
		input sda,
		output sda_s_oe
	);
endinterface
`default_nettype wire

// ### src/ep_slave.sv
/*
 Memory slave end: 256-byte array, 16-byte page buffer, programming timer,
 acknowledge logic and the address counter.
 Assumes scl and sda arrive asynchronously and that the master never
 stretches or drives scl from this side; sup_rst is on the clk domain.
*/
`timescale 1ns/10ps
`default_nettype none
module ep_slave #(
	parameter int PROG_CYC = ep_pkg::PROG_CYC
)
(
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// bus side
	ep_bus_if.slave bus,
	// user side
	input wire logic sup_rst,
	output logic prog_busy
);
	typedef enum logic [2:0]
	{
		S_IDLE = 3'b000,
		S_DEV = 3'b001,
		S_WORD = 3'b010,
		S_DATA = 3'b011,
		S_TX = 3'b100,
		S_WAIT = 3'b101
	} ep_sst_e;

	logic scl_m1, scl_s, scl_d, sda_m1, sda_s, sda_d;
	logic rise, fall, start_c, stop_c, commit;
	ep_sst_e st_reg, st_next;
	logic [3:0] bitc_reg, bitc_next;
	logic [7:0] sh_reg, sh_next;
	logic [7:0] addr_reg, addr_next;
	logic rw_reg, rw_next;
	logic oe_reg, oe_next;
	logic nack_reg, nack_next;
	logic busy_reg, busy_next;
	logic [31:0] cnt_reg, cnt_next;
	logic [15:0] mask_reg, mask_next;
	logic [7:0] buf_reg [ep_pkg::PAGE_N];
	logic [7:0] buf_next [ep_pkg::PAGE_N];
	logic [7:0] mem_reg [ep_pkg::MEM_N];

	// the first stage of each synchroniser feeds only the second
	always_ff @(posedge clk)
	begin
		scl_m1 <= bus.scl;
		scl_s <= scl_m1;
		scl_d <= scl_s;
		sda_m1 <= bus.sda;
		sda_s <= sda_m1;
		sda_d <= sda_s;
	end

	assign rise = scl_s & ~scl_d;
	assign fall = ~scl_s & scl_d;
	assign start_c = scl_s & scl_d & sda_d & ~sda_s;
	assign stop_c = scl_s & scl_d & ~sda_d & sda_s;
	assign bus.sda_s_oe = oe_reg;
	assign prog_busy = busy_reg;

	always_comb
	begin
		st_next = st_reg;
		bitc_next = bitc_reg;
		sh_next = sh_reg;
		addr_next = addr_reg;
		rw_next = rw_reg;
		oe_next = oe_reg;
		nack_next = nack_reg;
		busy_next = busy_reg;
		cnt_next = cnt_reg;
		mask_next = mask_reg;
		buf_next = buf_reg;
		commit = 1'b0;
		// the timer runs on regardless of supervisor reset
		if (busy_reg)
		begin
			if (cnt_reg == 32'h0)
			begin
				busy_next = 1'b0;
				commit = 1'b1;
				mask_next = ep_pkg::MASK_NONE;
			end
			else
			begin
				cnt_next = cnt_reg - 32'h1;
			end
		end
		if (sup_rst)
		begin
			st_next = S_IDLE;
			oe_next = 1'b0;
		end
		else if (start_c)
		begin
			st_next = S_DEV;
			bitc_next = 4'h0;
			oe_next = 1'b0;
		end
		else if (stop_c)
		begin
			// a dummy write leaves the mask empty and never programs
			if (st_reg == S_DATA && mask_reg != ep_pkg::MASK_NONE && !busy_reg)
			begin
				busy_next = 1'b1;
				cnt_next = 32'(PROG_CYC - 1);
			end
			st_next = S_IDLE;
			oe_next = 1'b0;
		end
		else
		begin
			case (st_reg)
				S_DEV, S_WORD, S_DATA:
				begin
					if (rise)
					begin
						if (bitc_reg < ep_pkg::BIT_ACK)
						begin
							sh_next = {sh_reg[6:0], sda_s};
						end
						if (bitc_reg != ep_pkg::BIT_END)
						begin
							bitc_next = bitc_reg + ep_pkg::BIT_STEP;
						end
					end
					else if (fall && bitc_reg == ep_pkg::BIT_ACK)
					begin
						if (st_reg == S_DEV)
						begin
							// busy or foreign address: stay silent
							if (sh_reg[7:1] == ep_pkg::DEV_ADDR && !busy_reg)
							begin
								oe_next = 1'b1;
								rw_next = sh_reg[0];
								mask_next = ep_pkg::MASK_NONE;
							end
							else
							begin
								st_next = S_IDLE;
							end
						end
						else if (st_reg == S_WORD)
						begin
							oe_next = 1'b1;
							addr_next = sh_reg;
						end
						else
						begin
							oe_next = 1'b1;
							buf_next[addr_reg[ep_pkg::OFF_W-1:0]] = sh_reg;
							mask_next[addr_reg[ep_pkg::OFF_W-1:0]] = 1'b1;
							addr_next = ep_pkg::ep_page_inc(addr_reg);
						end
					end
					else if (fall && bitc_reg == ep_pkg::BIT_END)
					begin
						oe_next = 1'b0;
						bitc_next = 4'h0;
						if (st_reg == S_DEV && rw_reg)
						begin
							sh_next = mem_reg[addr_reg];
							oe_next = ~mem_reg[addr_reg][7];
							addr_next = addr_reg + ep_pkg::ADDR_STEP;
							st_next = S_TX;
						end
						else if (st_reg == S_DEV)
						begin
							st_next = S_WORD;
						end
						else
						begin
							st_next = S_DATA;
						end
					end
				end
				S_TX:
				begin
					if (rise)
					begin
						if (bitc_reg == ep_pkg::BIT_ACK)
						begin
							nack_next = sda_s;
						end
						if (bitc_reg != ep_pkg::BIT_END)
						begin
							bitc_next = bitc_reg + ep_pkg::BIT_STEP;
						end
					end
					else if (fall)
					begin
						if (bitc_reg < ep_pkg::BIT_ACK)
						begin
							sh_next = {sh_reg[6:0], 1'b0};
							oe_next = ~sh_reg[6];
						end
						else if (bitc_reg == ep_pkg::BIT_ACK)
						begin
							oe_next = 1'b0;
						end
						else if (nack_reg)
						begin
							oe_next = 1'b0;
							st_next = S_WAIT;
						end
						else
						begin
							// counter wraps over the whole array, not the page
							bitc_next = 4'h0;
							sh_next = mem_reg[addr_reg];
							oe_next = ~mem_reg[addr_reg][7];
							addr_next = addr_reg + ep_pkg::ADDR_STEP;
						end
					end
				end
				default:
				begin
					oe_next = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			st_reg <= S_IDLE;
			bitc_reg <= 4'h0;
			sh_reg <= 8'h00;
			addr_reg <= 8'h00;
			rw_reg <= 1'b0;
			oe_reg <= 1'b0;
			nack_reg <= 1'b1;
			busy_reg <= 1'b0;
			cnt_reg <= 32'h0;
			mask_reg <= ep_pkg::MASK_NONE;
		end
		else
		begin
			st_reg <= st_next;
			bitc_reg <= bitc_next;
			sh_reg <= sh_next;
			addr_reg <= addr_next;
			rw_reg <= rw_next;
			oe_reg <= oe_next;
			nack_reg <= nack_next;
			busy_reg <= busy_next;
			cnt_reg <= cnt_next;
			mask_reg <= mask_next;
		end
	end

	// data storage holds no control state and is left without reset
	always_ff @(posedge clk)
	begin
		buf_reg <= buf_next;
		if (commit)
		begin
			for (int i = 0; i < ep_pkg::PAGE_N; i++)
			begin
				if (mask_reg[i])
				begin
					mem_reg[{addr_reg[ep_pkg::ADDR_W-1:ep_pkg::OFF_W], 4'(i)}] <= buf_reg[i];
				end
			end
		end
	end
endmodule
`default_nettype wire

// ### src/ep_master.sv
/*
 Bus controller end: turns byte-level commands into START, STOP and
 nine-clock byte frames, with the bus clock made by a quarter-period divider.
 Assumes the slave never stretches scl and commands come from the clk domain.
*/
`timescale 1ns/10ps
`default_nettype none
module ep_master
(
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// bus side
	ep_bus_if.master bus,
	// command
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic [1:0] cmd_op,
	input wire logic [7:0] cmd_data,
	input wire logic cmd_ack,
	// response
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	output logic rsp_ack
);
	typedef enum logic [1:0]
	{
		M_IDLE = 2'b00,
		M_START = 2'b01,
		M_BIT = 2'b10,
		M_STOP = 2'b11
	} ep_mst_e;

	logic sda_m1, sda_s, tick;
	ep_mst_e st_reg, st_next;
	logic [1:0] ph_reg, ph_next;
	logic [7:0] div_reg, div_next;
	logic [3:0] bitc_reg, bitc_next;
	logic [8:0] tx_reg, tx_next;
	logic [8:0] rx_reg, rx_next;
	logic scl_reg, scl_next;
	logic oe_reg, oe_next;
	logic rv_reg, rv_next;

	always_ff @(posedge clk)
	begin
		sda_m1 <= bus.sda;
		sda_s <= sda_m1;
	end

	assign tick = div_reg == 8'(ep_pkg::QTR_CYC - 1);
	assign cmd_ready = st_reg == M_IDLE;
	assign bus.scl = scl_reg;
	assign bus.sda_m_oe = oe_reg;
	assign rsp_valid = rv_reg;
	assign rsp_data = rx_reg[8:1];
	assign rsp_ack = ~rx_reg[0];

	always_comb
	begin
		st_next = st_reg;
		ph_next = ph_reg;
		div_next = tick ? 8'h00 : div_reg + 8'h01;
		bitc_next = bitc_reg;
		tx_next = tx_reg;
		rx_next = rx_reg;
		scl_next = scl_reg;
		oe_next = oe_reg;
		rv_next = 1'b0;
		case (st_reg)
			M_IDLE:
			begin
				div_next = 8'h00;
				ph_next = 2'h0;
				bitc_next = 4'h0;
				if (cmd_valid)
				begin
					case (ep_pkg::ep_op_e'(cmd_op))
						ep_pkg::OP_START: st_next = M_START;
						ep_pkg::OP_WRITE:
						begin
							// ninth bit released so the slave can answer
							tx_next = {cmd_data, 1'b1};
							st_next = M_BIT;
						end
						ep_pkg::OP_READ:
						begin
							tx_next = {8'hff, ~cmd_ack};
							st_next = M_BIT;
						end
						default: st_next = M_STOP;
					endcase
				end
			end
			default:
			begin
				if (tick)
				begin
					ph_next = ph_reg + 2'h1;
					case (ph_reg)
						2'h0: oe_next = st_reg == M_BIT ? ~tx_reg[8] : st_reg == M_STOP;
						2'h1: scl_next = 1'b1;
						2'h2:
						begin
							if (st_reg == M_BIT)
							begin
								rx_next = {rx_reg[7:0], sda_s};
							end
							else
							begin
								oe_next = st_reg == M_START;
							end
						end
						default:
						begin
							// a stop leaves scl high for the idle bus
							scl_next = st_reg == M_STOP;
							tx_next = {tx_reg[7:0], 1'b1};
							bitc_next = bitc_reg + 4'h1;
							if (st_reg != M_BIT || bitc_reg == ep_pkg::BIT_ACK)
							begin
								st_next = M_IDLE;
								rv_next = st_reg == M_BIT;
							end
						end
					endcase
				end
			end
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			st_reg <= M_IDLE;
			ph_reg <= 2'h0;
			div_reg <= 8'h00;
			bitc_reg <= 4'h0;
			tx_reg <= 9'h1ff;
			rx_reg <= 9'h1ff;
			scl_reg <= 1'b1;
			oe_reg <= 1'b0;
			rv_reg <= 1'b0;
		end
		else
		begin
			st_reg <= st_next;
			ph_reg <= ph_next;
			div_reg <= div_next;
			bitc_reg <= bitc_next;
			tx_reg <= tx_next;
			rx_reg <= rx_next;
			scl_reg <= scl_next;
			oe_reg <= oe_next;
			rv_reg <= rv_next;
		end
	end
endmodule
`default_nettype wire

// ### testbench/ep_link_assertions.sv
/*
 Concurrent checks on the two-wire link and the slave's programming flag.
 Assumes the wire and flag signals arrive as plain inputs on the clk domain.
*/
`timescale 1ns/10ps
`default_nettype none
module ep_link_assertions #(
	parameter int PROG_CYC = 200
)
(
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// wire
	input wire logic scl,
	input wire logic sda,
	input wire logic sda_m_oe,
	input wire logic sda_s_oe,
	// slave status
	input wire logic sup_rst,
	input wire logic prog_busy
);
	logic [1:0] line_reg, line_next;
	logic [7:0] age_reg, age_next;
	logic [15:0] cnt_reg, cnt_next;

	// age counts cycles since the last stop on the wire, saturating
	always_comb
	begin
		line_next = {scl, sda};
		age_next = age_reg + {7'h00, age_reg != 8'hff};
		if (sys_rst)
			age_next = 8'hff;
		else if (line_reg == 2'h2 && scl && sda)
			age_next = 8'h00;
		cnt_next = prog_busy ? cnt_reg + 16'h0001 : 16'h0000;
	end

	always_ff @(posedge clk)
	begin
		line_reg <= line_next;
		age_reg <= age_next;
		cnt_reg <= cnt_next;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	drive_on_low_a:
		assert property ($rose(sda_s_oe) |-> !scl ##1 (sda_s_oe && !scl)[*4])
		else $error("slave drive began outside clock low");
	hold_while_high_a:
		assert property ((scl && !sup_rst)[*4] |-> $stable(sda_s_oe))
		else $error("slave changed data while clock high");
	sole_driver_a:
		assert property (sda_m_oe && scl |-> !sda_s_oe)
		else $error("slave drove while master pulled low");
	busy_quiet_a:
		assert property (prog_busy[*8] |-> !sda_s_oe)
		else $error("slave drove during programming");
	poll_nack_a:
		assert property (prog_busy && $rose(scl) |-> !sda_s_oe)
		else $error("acknowledge seen while programming");
	busy_cause_a:
		assert property ($rose(prog_busy) |-> age_reg <= 8'h0c)
		else $error("programming began without a recent stop");
	busy_len_a:
		assert property ($fell(prog_busy) |-> cnt_reg >= PROG_CYC - 1 && cnt_reg <= PROG_CYC + 1)
		else $error("programming time wrong");
	sup_quiet_a:
		assert property (sup_rst[*4] |-> !sda_s_oe)
		else $error("slave drove under supervisor reset");
	sup_keeps_prog_a:
		assert property (sup_rst && prog_busy && cnt_reg < PROG_CYC - 2 |=> prog_busy)
		else $error("programming cut short by supervisor reset");
endmodule
`default_nettype wire

// ### testbench/testbench.sv
/*
 Self-checking bench: controller and memory slave joined on one link.
 Assumes ep_pkg, ep_bus_if and both design ends are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module testbench;
	// short programming time keeps the run small, still longer than one poll byte
	localparam int PROG = 3000;
	// row: kind (0 start, 1 write, 2 read, 3 stop, 4 wait idle), ack bit, byte
	localparam logic [11:0] ROWS [0:59] = '{
		12'h000, 12'h3a0, 12'h30f, 12'h311, 12'h322, 12'h333, 12'h600,
		12'h000, 12'h2a0, 12'h600, 12'h800,
		12'h000, 12'h3a0, 12'h3ff, 12'h344, 12'h600, 12'h800,
		12'h000, 12'h3a0, 12'h3ff, 12'h000, 12'h3a1, 12'h544, 12'h422, 12'h600,
		12'h000, 12'h3a1, 12'h433, 12'h600,
		12'h000, 12'h2a2, 12'h600,
		12'h000, 12'h3a0, 12'h30f, 12'h600, 12'h000, 12'h3a1, 12'h411, 12'h600,
		12'h000, 12'h3a0, 12'h306, 12'h355, 12'h600,
		12'h000, 12'h2a0, 12'h600, 12'h800,
		12'h000, 12'h3a0, 12'h306, 12'h000, 12'h3a1, 12'h455, 12'h600,
		12'h000, 12'h3a1, 12'h422, 12'h600
	};
	logic clk, sys_rst, sup_rst, cmd_valid, cmd_ack;
	logic cmd_ready, rsp_valid, rsp_ack, prog_busy;
	logic [1:0] cmd_op;
	logic [7:0] cmd_data, rsp_data;
	int bad_count = 0;
	int n_tests = 0;

	ep_bus_if bus();
	ep_master u_ep_master (.clk(clk), .sys_rst(sys_rst), .bus(bus), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_ack(cmd_ack),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ack(rsp_ack));
	ep_slave #(.PROG_CYC(PROG)) u_ep_slave (.clk(clk), .sys_rst(sys_rst), .bus(bus),
		.sup_rst(sup_rst), .prog_busy(prog_busy));
	ep_link_assertions #(.PROG_CYC(PROG)) u_ep_link_assertions (.clk(clk), .sys_rst(sys_rst),
		.scl(bus.scl), .sda(bus.sda), .sda_m_oe(bus.sda_m_oe), .sda_s_oe(bus.sda_s_oe),
		.sup_rst(sup_rst), .prog_busy(prog_busy));

	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ready is combinational idle, so a request raised while it is high is taken next edge
	task automatic run_cmd(input logic [1:0] op, input logic [7:0] d, input logic a);
		@(negedge clk);
		while (cmd_ready !== 1'b1)
			@(negedge clk);
		cmd_valid = 1'b1;
		cmd_op = op;
		cmd_data = d;
		cmd_ack = a;
		@(negedge clk);
		cmd_valid = 1'b0;
		if (op == ep_pkg::OP_WRITE || op == ep_pkg::OP_READ)
			while (rsp_valid !== 1'b1)
				@(negedge clk);
	endtask

	task automatic bus_idle();
		while (cmd_ready !== 1'b1)
			@(negedge clk);
		repeat (8) @(negedge clk);
	endtask

	task automatic run_rows(input int lo, input int hi);
		for (int i = lo; i <= hi; i++)
		begin
			if (ROWS[i][11])
			begin
				bus_idle();
				while (prog_busy !== 1'b0)
					@(negedge clk);
			end
			else
				run_cmd(ROWS[i][10:9], ROWS[i][7:0], ROWS[i][8]);
			if (ROWS[i][11:9] == 3'h1)
				`CHK(rsp_ack, ROWS[i][8])
			if (ROWS[i][11:9] == 3'h2)
				`CHK(rsp_data, ROWS[i][7:0])
		end
	endtask

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial
	begin
		repeat (100000) @(posedge clk);
		bad_count++;
		complete_run();
	end

	initial
	begin
		sys_rst = 1'b1;
		sup_rst = 1'b0;
		cmd_valid = 1'b0;
		cmd_op = 2'h0;
		cmd_data = 8'h00;
		cmd_ack = 1'b0;
		repeat (3) @(negedge clk);
		`CHK({bus.scl, bus.sda, prog_busy, cmd_ready, rsp_valid}, 5'h1a)
		sys_rst = 1'b0;
		repeat (4) @(negedge clk);
		run_rows(0, 44);
		// supervisor reset lands while the page is programming
		bus_idle();
		`CHK(prog_busy, 1'b1)
		sup_rst = 1'b1;
		run_rows(45, 48);
		sup_rst = 1'b0;
		repeat (4) @(negedge clk);
		run_rows(49, 55);
		// a second reset mid-run clears the counter but leaves the array alone
		bus_idle();
		sys_rst = 1'b1;
		repeat (3) @(negedge clk);
		`CHK({bus.scl, bus.sda, prog_busy, cmd_ready, rsp_valid}, 5'h1a)
		sys_rst = 1'b0;
		repeat (4) @(negedge clk);
		run_rows(56, 59);
		complete_run();
	end
endmodule
`default_nettype wire
